// ==== hdl/pbcs_pkg.sv ====
package pbcs_pkg;

   // Register indices; byte address on the bus is four times the index
   localparam logic [7:0] IDX_CTRL    = 8'h36;
   localparam logic [7:0] IDX_MULT_HI = 8'h38;
   localparam logic [7:0] IDX_MULT_LO = 8'h39;
   localparam logic [7:0] IDX_RANGE   = 8'h3A;
   localparam logic [7:0] IDX_REFDIV  = 8'h3B;
   localparam logic [7:0] IDX_OPTION  = 8'h3C;

   localparam logic [9:0] ADDR_CTRL    = {IDX_CTRL, 2'b00};
   localparam logic [9:0] ADDR_MULT_HI = {IDX_MULT_HI, 2'b00};
   localparam logic [9:0] ADDR_MULT_LO = {IDX_MULT_LO, 2'b00};
   localparam logic [9:0] ADDR_RANGE   = {IDX_RANGE, 2'b00};
   localparam logic [9:0] ADDR_REFDIV  = {IDX_REFDIV, 2'b00};
   localparam logic [9:0] ADDR_OPTION  = {IDX_OPTION, 2'b00};

   // Field positions in the synth control register and the option register
   localparam int unsigned BIT_ENABLE  = 5;
   localparam int unsigned BIT_SRC_SEL = 4;
   localparam int unsigned PRE_LSB     = 2;
   localparam int unsigned POW2_LSB    = 0;
   localparam int unsigned BIT_KEEP    = 0;

   // Values after reset
   localparam logic       RST_ENABLE  = 1'b1;
   localparam logic       RST_SRC_SEL = 1'b0;
   localparam logic [1:0] RST_PRE     = 2'h0;
   localparam logic [1:0] RST_POW2    = 2'h0;
   localparam logic [3:0] RST_MULT_HI = 4'h0;
   localparam logic [7:0] RST_MULT_LO = 8'h40;
   localparam logic [7:0] RST_RANGE   = 8'h40;
   localparam logic [3:0] RST_REFDIV  = 4'h1;
   localparam logic       RST_KEEP    = 1'b0;

   localparam int unsigned F_NOM_HZ = 38400;

   // Wait limit while the old source is drained or the new one is filled, in case either has stopped
   localparam int unsigned CLK_PERIOD_NS     = 10;
   localparam int unsigned HOLD_TIMEOUT_US   = 200;
   localparam int unsigned HOLD_TIMEOUT_CYC  = HOLD_TIMEOUT_US * 1000 / CLK_PERIOD_NS;
   localparam int unsigned SWITCH_EDGES      = 3;

   typedef enum logic [1:0] {
      SW_RUN   = 2'b00,
      SW_DRAIN = 2'b01,
      SW_FILL  = 2'b11
   } pbcs_sw_state_e;

   typedef struct packed {
      logic [1:0]  prescale;
      logic [1:0]  vco_pow2;
      logic [11:0] mult;
      logic [7:0]  vco_range;
      logic [3:0]  ref_div;
   } pbcs_cfg_s;

endpackage : pbcs_pkg

// ==== hdl/pbcs_clk_switch.sv ====
`timescale 1ns/1ns
module pbcs_clk_switch #(
   parameter int unsigned TIMEOUT_CYC = pbcs_pkg::HOLD_TIMEOUT_CYC
) (
   input  wire logic i_clk,
   input  wire logic i_reset_n,
   input  wire logic i_xtal_clk,
   input  wire logic i_vco_clk,
   input  wire logic i_sel_vco,
   output logic      o_clk,
   output logic      o_busy,
   output logic      o_cur_vco
);

   pbcs_pkg::pbcs_sw_state_e state;
   logic        xtal_q;
   logic        vco_q;
   logic        cur_vco;
   logic [1:0]  edge_cnt;
   logic [15:0] tmo_cnt;
   logic        xtal_rise;
   logic        vco_rise;
   logic        cur_rise;
   logic        last_edge;
   logic        timed_out;

   assign xtal_rise = i_xtal_clk & ~xtal_q;
   assign vco_rise  = i_vco_clk & ~vco_q;
   assign cur_rise  = cur_vco ? vco_rise : xtal_rise;
   assign last_edge = cur_rise && (edge_cnt == 2'(pbcs_pkg::SWITCH_EDGES - 1));
   assign timed_out = (tmo_cnt == 16'(TIMEOUT_CYC - 1));

   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         xtal_q <= 1'b0;
         vco_q  <= 1'b0;
      end else begin
         xtal_q <= i_xtal_clk;
         vco_q  <= i_vco_clk;
      end
   end

   // Each source is counted on its own edges, so a change waits out three
   // edges of the leaving clock and three of the arriving one
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         state    <= pbcs_pkg::SW_RUN;
         cur_vco  <= 1'b0;
         edge_cnt <= 2'h0;
         tmo_cnt  <= 16'h0000;
      end else begin
         case (state)
            pbcs_pkg::SW_RUN: begin
               edge_cnt <= 2'h0;
               tmo_cnt  <= 16'h0000;
               if (i_sel_vco != cur_vco) begin
                  state <= pbcs_pkg::SW_DRAIN;
               end
            end
            pbcs_pkg::SW_DRAIN: begin
               if (last_edge || timed_out) begin
                  state    <= pbcs_pkg::SW_FILL;
                  cur_vco  <= ~cur_vco;
                  edge_cnt <= 2'h0;
                  tmo_cnt  <= 16'h0000;
               end else begin
                  edge_cnt <= edge_cnt + 2'(cur_rise);
                  tmo_cnt  <= tmo_cnt + 16'h0001;
               end
            end
            pbcs_pkg::SW_FILL: begin
               if (last_edge || timed_out) begin
                  state <= pbcs_pkg::SW_RUN;
               end else begin
                  edge_cnt <= edge_cnt + 2'(cur_rise);
                  tmo_cnt  <= tmo_cnt + 16'h0001;
               end
            end
            default: state <= pbcs_pkg::SW_RUN;
         endcase
      end
   end

   // Halving on rising edges gives a 50 percent duty cycle whatever the source duty
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         o_clk <= 1'b0;
      end else if (state == pbcs_pkg::SW_RUN && cur_rise) begin
         o_clk <= ~o_clk;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         o_busy    <= 1'b0;
         o_cur_vco <= 1'b0;
      end else begin
         o_busy    <= (state != pbcs_pkg::SW_RUN);
         o_cur_vco <= cur_vco;
      end
   end

   property p_hold_static;
      @(posedge i_clk) disable iff (!i_reset_n)
      (state != pbcs_pkg::SW_RUN) |=> $stable(o_clk);
   endproperty
   a_hold_static: assert property (p_hold_static) else $error("output moved in hold");

   property p_halve;
      @(posedge i_clk) disable iff (!i_reset_n)
      (state == pbcs_pkg::SW_RUN && cur_rise) |=> (o_clk != $past(o_clk));
   endproperty
   a_halve: assert property (p_halve) else $error("base clock missed a toggle");

   property p_switch_needs_edges;
      @(posedge i_clk) disable iff (!i_reset_n)
      (state == pbcs_pkg::SW_RUN && i_sel_vco != cur_vco) |=> ##1 (state != pbcs_pkg::SW_RUN);
   endproperty
   a_switch_needs_edges: assert property (p_switch_needs_edges)
      else $error("source swapped too soon");

endmodule : pbcs_clk_switch

// ==== hdl/pbcs_top.sv ====
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
module pbcs_top #(
   parameter int unsigned HOLD_TIMEOUT_CYC = pbcs_pkg::HOLD_TIMEOUT_CYC
) (
   input  wire logic                 i_clk,
   input  wire logic                 i_reset_n,
   input  wire logic                 i_psel,
   input  wire logic                 i_penable,
   input  wire logic                 i_pwrite,
   input  wire logic [9:0]           i_paddr,
   input  wire logic [31:0]          i_pwdata,
   output logic                      o_pready,
   output logic [31:0]               o_prdata,
   output logic                      o_pslverr,
   input  wire logic                 i_xtal_clk,
   input  wire logic                 i_vco_clk,
   input  wire logic                 i_osc_enable_in,
   input  wire logic                 i_stop_mode,
   output logic                      o_base_clk_out,
   output logic                      o_switch_busy,
   output logic                      o_vco_selected,
   output logic                      o_osc_run,
   output logic                      o_synth_run,
   output pbcs_pkg::pbcs_cfg_s       o_cfg,
   output logic [26:0]               o_centre_hz
);

   logic        synth_enable;
   logic        base_src_select;
   logic [1:0]  prescale;
   logic [1:0]  vco_pow2_field;
   logic [3:0]  mult_high_reg;
   logic [7:0]  mult_low_reg;
   logic [7:0]  vco_range_reg;
   logic [3:0]  ref_divider_reg;
   logic        osc_stop_keep;

   logic        setup;
   logic        wr_go;
   logic        mapped;
   logic [7:0]  ctrl_rd;
   logic [31:0] next_rdata;
   logic        next_enable;
   logic        next_src_sel;
   logic        range_zero;
   logic        sel_vco;
   logic        sw_clk;
   logic        sw_busy;
   logic        sw_cur_vco;
   logic [11:0] mult_raw;
   logic [10:0] scaled_range;

   assign setup      = i_psel & ~i_penable;
   assign wr_go      = i_psel & i_penable & o_pready & i_pwrite;
   assign range_zero = (vco_range_reg == 8'h00);
   assign mult_raw   = {mult_high_reg, mult_low_reg};

   assign ctrl_rd = {2'b00, synth_enable, base_src_select, prescale, vco_pow2_field};

   always_comb begin
      mapped = 1'b1;
      next_rdata = 32'h0000_0000;
      case (i_paddr)
         pbcs_pkg::ADDR_CTRL:    next_rdata = {24'h000000, ctrl_rd};
         pbcs_pkg::ADDR_MULT_HI: next_rdata = {28'h0000000, mult_high_reg};
         pbcs_pkg::ADDR_MULT_LO: next_rdata = {24'h000000, mult_low_reg};
         pbcs_pkg::ADDR_RANGE:   next_rdata = {24'h000000, vco_range_reg};
         pbcs_pkg::ADDR_REFDIV:  next_rdata = {28'h0000000, ref_divider_reg};
         pbcs_pkg::ADDR_OPTION:  next_rdata = {31'h00000000, osc_stop_keep};
         default:                mapped = 1'b0;
      endcase
   end

   // Answer is prepared in the setup cycle, so every access phase is one cycle
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         o_pready  <= 1'b0;
         o_prdata  <= 32'h0000_0000;
         o_pslverr <= 1'b0;
      end else if (setup) begin
         o_pready  <= 1'b1;
         o_prdata  <= i_pwrite ? 32'h0000_0000 : next_rdata;
         o_pslverr <= ~mapped;
      end else begin
         o_pready  <= 1'b0;
         o_pslverr <= 1'b0;
      end
   end

   // Select is judged against the stored enable, and a standing or newly
   // granted select holds the enable on, so no single write moves both bits
   always_comb begin
      next_enable  = i_pwdata[pbcs_pkg::BIT_ENABLE];
      next_src_sel = i_pwdata[pbcs_pkg::BIT_SRC_SEL];
      if (!synth_enable || range_zero) begin
         next_src_sel = 1'b0;
      end
      if (base_src_select || next_src_sel) begin
         next_enable = 1'b1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         synth_enable    <= pbcs_pkg::RST_ENABLE;
         base_src_select <= pbcs_pkg::RST_SRC_SEL;
      end else if (range_zero) begin
         synth_enable    <= synth_enable;
         base_src_select <= 1'b0;
         if (wr_go && i_paddr == pbcs_pkg::ADDR_CTRL) begin
            synth_enable <= next_enable;
         end
      end else if (wr_go && i_paddr == pbcs_pkg::ADDR_CTRL) begin
         synth_enable    <= next_enable;
         base_src_select <= next_src_sel;
      end
   end

   // Prescaler is frozen while the loop runs; the exponent stays writable
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         prescale       <= pbcs_pkg::RST_PRE;
         vco_pow2_field <= pbcs_pkg::RST_POW2;
      end else if (wr_go && i_paddr == pbcs_pkg::ADDR_CTRL) begin
         if (!synth_enable) begin
            prescale <= i_pwdata[pbcs_pkg::PRE_LSB +: 2];
         end
         vco_pow2_field <= i_pwdata[pbcs_pkg::POW2_LSB +: 2];
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         mult_high_reg   <= pbcs_pkg::RST_MULT_HI;
         mult_low_reg    <= pbcs_pkg::RST_MULT_LO;
         vco_range_reg   <= pbcs_pkg::RST_RANGE;
         ref_divider_reg <= pbcs_pkg::RST_REFDIV;
      end else if (wr_go) begin
         if (i_paddr == pbcs_pkg::ADDR_MULT_HI) begin
            mult_high_reg <= i_pwdata[3:0];
         end
         if (i_paddr == pbcs_pkg::ADDR_MULT_LO) begin
            mult_low_reg <= i_pwdata[7:0];
         end
         if (i_paddr == pbcs_pkg::ADDR_RANGE) begin
            vco_range_reg <= i_pwdata[7:0];
         end
         if (i_paddr == pbcs_pkg::ADDR_REFDIV) begin
            ref_divider_reg <= i_pwdata[3:0];
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         osc_stop_keep <= pbcs_pkg::RST_KEEP;
      end else if (wr_go && i_paddr == pbcs_pkg::ADDR_OPTION) begin
         osc_stop_keep <= i_pwdata[pbcs_pkg::BIT_KEEP];
      end
   end

   // Effective loop settings as the analog side must see them
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         o_cfg <= '{prescale: pbcs_pkg::RST_PRE, vco_pow2: pbcs_pkg::RST_POW2,
                    mult: {pbcs_pkg::RST_MULT_HI, pbcs_pkg::RST_MULT_LO},
                    vco_range: pbcs_pkg::RST_RANGE, ref_div: pbcs_pkg::RST_REFDIV};
      end else begin
         o_cfg.prescale  <= prescale;
         o_cfg.vco_pow2  <= vco_pow2_field;
         o_cfg.mult      <= (mult_raw == 12'h000) ? 12'h001 : mult_raw;
         o_cfg.vco_range <= vco_range_reg;
         o_cfg.ref_div   <= (ref_divider_reg == 4'h0) ? 4'h1 : ref_divider_reg;
      end
   end

   // An exponent of three is not a legal setting; the shifted range is sized to survive it
   assign scaled_range = 11'({3'b000, vco_range_reg} << vco_pow2_field);

   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         o_centre_hz <= 27'h0000000;
      end else begin
         o_centre_hz <= 27'(scaled_range * 27'(pbcs_pkg::F_NOM_HZ));
      end
   end

   // The integration unit owns the oscillator enable; stop mode only acts when
   // the keep option says the oscillator must survive stop, and then holds it on
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         o_osc_run   <= 1'b0;
         o_synth_run <= 1'b0;
      end else begin
         o_osc_run   <= i_osc_enable_in | (osc_stop_keep & i_stop_mode);
         o_synth_run <= i_osc_enable_in & synth_enable & ~range_zero;
      end
   end

   assign sel_vco = base_src_select & synth_enable & ~range_zero;

   pbcs_clk_switch #(
      .TIMEOUT_CYC (HOLD_TIMEOUT_CYC)
   ) u_switch (
      .i_clk      (i_clk),
      .i_reset_n  (i_reset_n),
      .i_xtal_clk (i_xtal_clk),
      .i_vco_clk  (i_vco_clk),
      .i_sel_vco  (sel_vco),
      .o_clk      (sw_clk),
      .o_busy     (sw_busy),
      .o_cur_vco  (sw_cur_vco)
   );

   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         o_base_clk_out <= 1'b0;
         o_switch_busy  <= 1'b0;
         o_vco_selected <= 1'b0;
      end else begin
         o_base_clk_out <= sw_clk;
         o_switch_busy  <= sw_busy;
         o_vco_selected <= sw_cur_vco;
      end
   end

   property p_refuse_select;
      @(posedge i_clk) disable iff (!i_reset_n)
      (wr_go && i_paddr == pbcs_pkg::ADDR_CTRL && !synth_enable) |=> !base_src_select;
   endproperty
   a_refuse_select: assert property (p_refuse_select) else $error("VCO select taken");

   property p_refuse_disable;
      @(posedge i_clk) disable iff (!i_reset_n)
      (wr_go && i_paddr == pbcs_pkg::ADDR_CTRL && base_src_select && !range_zero)
         |=> synth_enable;
   endproperty
   a_refuse_disable: assert property (p_refuse_disable) else $error("disable taken");

   property p_one_step;
      @(posedge i_clk) disable iff (!i_reset_n)
      (wr_go && i_paddr == pbcs_pkg::ADDR_CTRL)
         |=> !($changed(synth_enable) && $changed(base_src_select));
   endproperty
   a_one_step: assert property (p_one_step) else $error("two bits in one write");

   property p_zero_range;
      @(posedge i_clk) disable iff (!i_reset_n)
      range_zero |=> (!base_src_select && !o_synth_run);
   endproperty
   a_zero_range: assert property (p_zero_range) else $error("zero range left VCO usable");

   property p_zero_as_one;
      @(posedge i_clk) disable iff (!i_reset_n)
      (ref_divider_reg == 4'h0 && mult_raw == 12'h000)
         |=> (o_cfg.ref_div == 4'h1 && o_cfg.mult == 12'h001);
   endproperty
   a_zero_as_one: assert property (p_zero_as_one) else $error("zero not read as one");

   property p_osc_keep;
      @(posedge i_clk) disable iff (!i_reset_n)
      (osc_stop_keep && i_stop_mode) |=> o_osc_run;
   endproperty
   a_osc_keep: assert property (p_osc_keep) else $error("oscillator stopped");

   property p_osc_follow;
      @(posedge i_clk) disable iff (!i_reset_n)
      !osc_stop_keep |=> (o_osc_run == $past(i_osc_enable_in));
   endproperty
   a_osc_follow: assert property (p_osc_follow) else $error("oscillator ignored enable");

   property p_pre_lock;
      @(posedge i_clk) disable iff (!i_reset_n)
      (wr_go && i_paddr == pbcs_pkg::ADDR_CTRL && synth_enable) |=> $stable(prescale);
   endproperty
   a_pre_lock: assert property (p_pre_lock) else $error("prescaler moved");

   property p_mult_pair;
      @(posedge i_clk) disable iff (!i_reset_n)
      (mult_raw != 12'h000) |=> (o_cfg.mult == $past(mult_raw));
   endproperty
   a_mult_pair: assert property (p_mult_pair) else $error("multiplier halves split");

endmodule : pbcs_top

// ==== tb/pbcs_sim_model.sv ====
`timescale 1ns/1ns
module pbcs_sim_model (
   input  wire logic i_clk,
   input  wire logic i_reset_n,
   input  wire logic i_stop_req,
   input  wire logic i_base_clk,
   output logic      o_osc_enable,
   output logic      o_stop_mode,
   output logic      o_bus_clk
);
   logic base_q;

   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         o_stop_mode  <= 1'b0;
         o_osc_enable <= 1'b1;
      end else begin
         o_stop_mode  <= i_stop_req;
         o_osc_enable <= !i_stop_req;
      end
   end

   // Bus clock is half the base clock, so a quarter of the source
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         base_q    <= 1'b0;
         o_bus_clk <= 1'b0;
      end else begin
         base_q <= i_base_clk;
         if (i_base_clk && !base_q) begin
            o_bus_clk <= !o_bus_clk;
         end
      end
   end
endmodule : pbcs_sim_model

// ==== tb/tb_top.sv ====
`timescale 1ns/1ns
module tb_top;
   typedef struct packed {
      logic        wr;
      logic [9:0]  addr;
      logic [31:0] wdata;
      logic [31:0] exp;
      logic        err;
   } pbcs_row_s;

   logic                i_clk, i_reset_n, i_psel, i_penable, i_pwrite;
   logic [9:0]          i_paddr;
   logic [31:0]         i_pwdata, o_prdata, rd;
   logic                o_pready, o_pslverr, er, xtal, vco, stop_req, osc_en, stop_mode;
   logic                o_base_clk_out, o_switch_busy, o_vco_selected, o_osc_run;
   logic                o_synth_run, bus_clk, busy_q, base_q;
   pbcs_pkg::pbcs_cfg_s o_cfg;
   logic [26:0]         o_centre_hz;
   int                  mismatches, cmp_count, i, n;

   pbcs_row_s rows [19] = '{
      '{1'b0, pbcs_pkg::ADDR_CTRL, 32'h0, 32'h20, 1'b0},
      '{1'b0, pbcs_pkg::ADDR_MULT_HI, 32'h0, 32'h0, 1'b0},
      '{1'b0, pbcs_pkg::ADDR_MULT_LO, 32'h0, 32'h40, 1'b0},
      '{1'b0, pbcs_pkg::ADDR_RANGE, 32'h0, 32'h40, 1'b0},
      '{1'b0, pbcs_pkg::ADDR_REFDIV, 32'h0, 32'h1, 1'b0},
      '{1'b0, pbcs_pkg::ADDR_OPTION, 32'h0, 32'h0, 1'b0},
      '{1'b1, pbcs_pkg::ADDR_CTRL, 32'h22, 32'h22, 1'b0},
      '{1'b1, pbcs_pkg::ADDR_CTRL, 32'h2C, 32'h20, 1'b0},
      '{1'b1, pbcs_pkg::ADDR_CTRL, 32'h0C, 32'h00, 1'b0},
      '{1'b1, pbcs_pkg::ADDR_CTRL, 32'h0C, 32'h0C, 1'b0},
      '{1'b1, pbcs_pkg::ADDR_CTRL, 32'h30, 32'h20, 1'b0},
      '{1'b1, pbcs_pkg::ADDR_CTRL, 32'h32, 32'h32, 1'b0},
      '{1'b1, pbcs_pkg::ADDR_CTRL, 32'h02, 32'h22, 1'b0},
      '{1'b1, pbcs_pkg::ADDR_MULT_HI, 32'hFFFFFFF5, 32'h5, 1'b0},
      '{1'b1, pbcs_pkg::ADDR_MULT_LO, 32'hA7, 32'hA7, 1'b0},
      '{1'b1, pbcs_pkg::ADDR_RANGE, 32'h83, 32'h83, 1'b0},
      '{1'b1, pbcs_pkg::ADDR_REFDIV, 32'h2C, 32'hC, 1'b0},
      '{1'b1, pbcs_pkg::ADDR_OPTION, 32'h1, 32'h1, 1'b0},
      '{1'b1, 10'h0DC, 32'h55, 32'h0, 1'b1}
   };

   pbcs_top #(.HOLD_TIMEOUT_CYC(1000)) u_pbcs_top (
      .i_clk(i_clk), .i_reset_n(i_reset_n), .i_psel(i_psel), .i_penable(i_penable),
      .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready),
      .o_prdata(o_prdata), .o_pslverr(o_pslverr), .i_xtal_clk(xtal), .i_vco_clk(vco),
      .i_osc_enable_in(osc_en), .i_stop_mode(stop_mode), .o_base_clk_out(o_base_clk_out),
      .o_switch_busy(o_switch_busy), .o_vco_selected(o_vco_selected),
      .o_osc_run(o_osc_run), .o_synth_run(o_synth_run), .o_cfg(o_cfg),
      .o_centre_hz(o_centre_hz));

   pbcs_sim_model u_pbcs_sim_model (
      .i_clk(i_clk), .i_reset_n(i_reset_n), .i_stop_req(stop_req),
      .i_base_clk(o_base_clk_out), .o_osc_enable(osc_en), .o_stop_mode(stop_mode),
      .o_bus_clk(bus_clk));

   // Source clocks never toggle on an i_clk rising edge
   initial begin i_clk = 1'b0; forever #5 i_clk = ~i_clk; end
   initial begin xtal = 1'b0; forever #40 xtal = ~xtal; end
   initial begin vco = 1'b0; forever #30 vco = ~vco; end

   task automatic conclude();
      if (mismatches == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : conclude

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
         mismatches++;
      end
   endtask : chk

   task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
      int k;
      i_psel <= 1'b1; i_penable <= 1'b0; i_pwrite <= w; i_paddr <= a; i_pwdata <= d;
      @(posedge i_clk);
      i_penable <= 1'b1;
      k = 0;
      do begin @(posedge i_clk); k++; end while (o_pready !== 1'b1 && k < 20);
      if (k >= 20) begin mismatches++; conclude(); end
      rd = o_prdata;
      er = o_pslverr;
      i_psel <= 1'b0; i_penable <= 1'b0;
      @(posedge i_clk);
   endtask : apb

   task automatic wait_busy(input logic v);
      for (n = 0; n < 500 && o_switch_busy !== v; n++) @(posedge i_clk);
      if (n >= 500) begin mismatches++; conclude(); end
   endtask : wait_busy

   // Rising edges of the bus clock over a window, within one edge
   task automatic bus_edges(input int cyc, input int e);
      int c;
      logic p;
      c = 0;
      p = bus_clk;
      repeat (cyc) begin @(posedge i_clk); if (bus_clk && !p) c++; p = bus_clk; end
      chk(32'(c >= e - 1 && c <= e + 1), 32'h1);
   endtask : bus_edges

   always @(posedge i_clk) begin
      if (busy_q && o_switch_busy === 1'b1) chk(32'(o_base_clk_out), 32'(base_q));
      busy_q <= (o_switch_busy === 1'b1);
      base_q <= o_base_clk_out;
   end

   initial begin
      mismatches = 0; cmp_count = 0; busy_q = 1'b0; base_q = 1'b0;
      i_reset_n = 1'b0; i_psel = 1'b0; i_penable = 1'b0; i_pwrite = 1'b0;
      i_paddr = 10'h0; i_pwdata = 32'h0; stop_req = 1'b0;
      repeat (4) @(posedge i_clk);
      i_reset_n <= 1'b1;
      @(posedge i_clk);
      for (i = 0; i < 19; i++) begin
         if (rows[i].wr) begin
            apb(1'b1, rows[i].addr, rows[i].wdata);
            chk(32'(er), 32'(rows[i].err));
         end
         apb(1'b0, rows[i].addr, 32'h0);
         chk(rd, rows[i].exp);
         chk(32'(er), 32'(rows[i].err));
      end
      repeat (2) @(posedge i_clk);
      chk(32'(o_cfg), 32'({2'h0, 2'h2, 12'h5A7, 8'h83, 4'hC}));
      chk(32'(o_centre_hz), 32'(131 * 4 * 38400));
      apb(1'b1, pbcs_pkg::ADDR_MULT_HI, 32'h0);
      apb(1'b1, pbcs_pkg::ADDR_MULT_LO, 32'h0);
      apb(1'b1, pbcs_pkg::ADDR_REFDIV, 32'h0);
      repeat (2) @(posedge i_clk);
      chk(32'(o_cfg.mult), 32'h1);
      chk(32'(o_cfg.ref_div), 32'h1);
      wait_busy(1'b0);
      bus_edges(480, 15);
      // Exponent stays at 2: software never programs 3 here
      // Select with enable bit clear: the enable must stay on
      apb(1'b1, pbcs_pkg::ADDR_CTRL, 32'h12);
      wait_busy(1'b1);
      for (n = 0; n < 200 && o_switch_busy === 1'b1; n++) @(posedge i_clk);
      chk(32'(n >= 28 && n <= 56), 32'h1);
      chk(32'(o_vco_selected), 32'h1);
      apb(1'b0, pbcs_pkg::ADDR_CTRL, 32'h0);
      chk(rd, 32'h32);
      bus_edges(480, 20);
      chk(32'(o_synth_run), 32'h1);
      apb(1'b1, pbcs_pkg::ADDR_RANGE, 32'h0);
      apb(1'b0, pbcs_pkg::ADDR_CTRL, 32'h0);
      chk(rd, 32'h22);
      apb(1'b1, pbcs_pkg::ADDR_CTRL, 32'h32);
      apb(1'b0, pbcs_pkg::ADDR_CTRL, 32'h0);
      chk(rd, 32'h22);
      wait_busy(1'b0);
      chk(32'(o_vco_selected), 32'h0);
      chk(32'(o_synth_run), 32'h0);
      stop_req <= 1'b1;
      repeat (4) @(posedge i_clk);
      chk(32'(o_osc_run), 32'h1);
      apb(1'b1, pbcs_pkg::ADDR_OPTION, 32'h0);
      repeat (3) @(posedge i_clk);
      chk(32'(o_osc_run), 32'h0);
      stop_req <= 1'b0;
      repeat (4) @(posedge i_clk);
      chk(32'(o_osc_run), 32'h1);
      conclude();
   end
endmodule : tb_top
